// File: rtl/ssx_pkg.sv
// shared constants and types for the subtract/swap/sleep execution block
// How it works
// - A power-down instruction decodes in Q1, idles in Q2 and Q3, and goes to sleep in Q4.
// - Subtract-from-literal is opcode bits 13:12 = 11 and bits 11:9 = 110, bit 8 ignored.
// - Subtract-from-literal writes the literal minus W into W, in two's complement.
// - After a subtraction carry is 1 for a zero or positive result and 0 on a borrow.
// - Both subtractions update carry, digit carry and zero; zero is set only for result 0.
// - Subtract-from-file (group 0010) computes f minus W, into W when d is 0, f when 1.
// - Nibble swap (group 1110) exchanges bits 3:0 and 7:4 of the addressed file register.
// - The swap result goes to W when d is 0 and back to the file register when d is 1.
// - Power-down clears the power-down bit, sets the time-out bit, clears the watchdog.
// - Entering power-down stops the main oscillator.
package ssx_pkg;
  // ****************************************************************
  // register map, byte addresses on the bus
  // ****************************************************************
  localparam logic [7:0] SSX_ADR_INSTR = 8'h00;
  localparam logic [7:0] SSX_ADR_WREG = 8'h04;
  localparam logic [7:0] SSX_ADR_STATUS = 8'h08;
  // status fields
  localparam int SSX_ST_C = 0;
  localparam int SSX_ST_DC = 1;
  localparam int SSX_ST_Z = 2;
  localparam int SSX_ST_PD = 3;
  localparam int SSX_ST_TO = 4;
  localparam int SSX_ST_SLEEP = 5;
  localparam int SSX_ST_BUSY = 6;
  localparam int SSX_ST_WAKE = 7;
  // reset values
  localparam logic [7:0] SSX_W_RST = 8'h00;
  localparam logic [13:0] SSX_INSTR_RST = 14'h0000;
  localparam logic SSX_PD_RST = 1'b1;
  localparam logic SSX_TO_RST = 1'b1;
  // ****************************************************************
  // opcode fields
  // ****************************************************************
  localparam int SSX_IW = 14;
  localparam logic [1:0] SSX_TOP_LIT = 2'h3;
  localparam logic [1:0] SSX_TOP_FILE = 2'h0;
  localparam logic [2:0] SSX_GRP_SUBL = 3'h6;
  localparam logic [3:0] SSX_GRP_SUBF = 4'h2;
  localparam logic [3:0] SSX_GRP_SWAP = 4'hE;
  localparam logic [13:0] SSX_OPC_SLEEP = 14'h0063;
  localparam int SSX_D_BIT = 7;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {SSX_OP_NONE, SSX_OP_SUBL, SSX_OP_SUBF, SSX_OP_SWAP} ssx_alu_op_t;
  typedef enum logic [2:0] {SSX_PH_IDLE, SSX_PH_Q1, SSX_PH_Q2, SSX_PH_Q3, SSX_PH_Q4}
    ssx_phase_t;
endpackage

// File: rtl/ssx_alu_if.sv
// interface between the sequencer and the arithmetic unit
`timescale 1ns/100ps
interface ssx_alu_if;
  ssx_pkg::ssx_alu_op_t op;
  logic [7:0] opa;
  logic [7:0] w;
  logic [7:0] res;
  logic c;
  logic dc;
  logic z;
  logic flags_upd;
  modport core (output op, opa, w, input res, c, dc, z, flags_upd);
  modport alu (input op, opa, w, output res, c, dc, z, flags_upd);
endinterface

// File: rtl/ssx_alu.sv
// arithmetic unit: subtraction and nibble swap with flag results
`timescale 1ns/100ps
module ssx_alu (
  // operands and results
  ssx_alu_if.alu a
);
  // ****************************************************************
  // subtraction as opa + ~w + 1
  // ****************************************************************
  wire [8:0] diff = {1'b0, a.opa} + {1'b0, ~a.w} + 9'h001;
  wire [4:0] ldiff = {1'b0, a.opa[3:0]} + {1'b0, ~a.w[3:0]} + 5'h01;
  wire is_sub = (a.op == ssx_pkg::SSX_OP_SUBL) || (a.op == ssx_pkg::SSX_OP_SUBF);
  wire [7:0] swapped = {a.opa[3:0], a.opa[7:4]};
  // result and flags
  assign a.res = is_sub ? diff[7:0] : swapped;
  assign a.c = diff[8];
  assign a.dc = ldiff[4];
  assign a.z = (diff[7:0] == 8'h00);
  assign a.flags_upd = is_sub;
endmodule

// File: rtl/ssx_core.sv
// execution core for subtract, nibble swap and power-down, with wishbone registers
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
module ssx_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // file register port
  output logic [6:0] file_addr_o,
  input wire logic [7:0] file_rdata_i,
  output logic file_we_o,
  output logic [7:0] file_wdata_o,
  // power-down control
  output logic sleep_o,
  output logic osc_stop_o,
  output logic wdt_clr_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  ssx_pkg::ssx_phase_t ph_ff, nxt_ph;
  logic [13:0] instr_ff;
  logic [7:0] w_ff, opa_ff;
  logic c_ff, dc_ff, z_ff, pd_ff, to_ff, sleep_ff;
  logic ack_ff, file_we_ff, wdt_clr_ff;
  logic [31:0] dat_ff;
  logic [6:0] file_addr_ff;
  logic [7:0] file_wdata_ff;
  ssx_alu_if alu_bus ();

  // bus decode
  wire req = wb_cyc_i && wb_stb_i && !ack_ff;
  wire wr = req && wb_we_i;
  wire hit_instr = (wb_adr_i == ssx_pkg::SSX_ADR_INSTR);
  wire hit_w = (wb_adr_i == ssx_pkg::SSX_ADR_WREG);
  wire hit_st = (wb_adr_i == ssx_pkg::SSX_ADR_STATUS);
  wire busy = (ph_ff != ssx_pkg::SSX_PH_IDLE);
  wire start = wr && hit_instr && (wb_sel_i[1:0] == 2'h3) && !busy && !sleep_ff;
  wire wr_w = wr && hit_w && wb_sel_i[0];
  wire wr_st = wr && hit_st && wb_sel_i[0];
  wire wake = wr_st && wb_dat_i[ssx_pkg::SSX_ST_WAKE];

  // opcode decode
  wire [1:0] top = instr_ff[13:12];
  wire is_subl = (top == ssx_pkg::SSX_TOP_LIT) && (instr_ff[11:9] == ssx_pkg::SSX_GRP_SUBL);
  wire is_subf = (top == ssx_pkg::SSX_TOP_FILE) && (instr_ff[11:8] == ssx_pkg::SSX_GRP_SUBF);
  wire is_swap = (top == ssx_pkg::SSX_TOP_FILE) && (instr_ff[11:8] == ssx_pkg::SSX_GRP_SWAP);
  wire is_sleep = (instr_ff == ssx_pkg::SSX_OPC_SLEEP);
  wire dest_f = instr_ff[ssx_pkg::SSX_D_BIT];
  wire in_q4 = (ph_ff == ssx_pkg::SSX_PH_Q4);
  wire commit = in_q4 && (is_subl || is_subf || is_swap);
  wire to_file = commit && !is_subl && dest_f;
  wire to_w = commit && !to_file;
  wire go_sleep = in_q4 && is_sleep;

  // arithmetic unit hookup
  assign alu_bus.op = is_subl ? ssx_pkg::SSX_OP_SUBL : is_subf ? ssx_pkg::SSX_OP_SUBF :
    is_swap ? ssx_pkg::SSX_OP_SWAP : ssx_pkg::SSX_OP_NONE;
  assign alu_bus.opa = opa_ff;
  assign alu_bus.w = w_ff;
  ssx_alu u_alu (
    .a(alu_bus)
  );

  // read mux, unmapped reads give zero
  wire [7:0] st_rd = {1'b0, busy, sleep_ff, to_ff, pd_ff, z_ff, dc_ff, c_ff};
  wire [31:0] rd = hit_instr ? {18'h00000, instr_ff} : hit_w ? {24'h000000, w_ff} :
    hit_st ? {24'h000000, st_rd} : 32'h00000000;

  // ****************************************************************
  // four quarter-cycle sequencer
  // ****************************************************************
  always_comb begin
    nxt_ph = ph_ff;
    unique case (ph_ff)
      ssx_pkg::SSX_PH_IDLE: if (start) nxt_ph = ssx_pkg::SSX_PH_Q1;
      ssx_pkg::SSX_PH_Q1: nxt_ph = ssx_pkg::SSX_PH_Q2;
      ssx_pkg::SSX_PH_Q2: nxt_ph = ssx_pkg::SSX_PH_Q3;
      ssx_pkg::SSX_PH_Q3: nxt_ph = ssx_pkg::SSX_PH_Q4;
      ssx_pkg::SSX_PH_Q4: nxt_ph = ssx_pkg::SSX_PH_IDLE;
      default: nxt_ph = ssx_pkg::SSX_PH_IDLE;
    endcase
  end

  // phase register
  always_ff @(posedge clk_i) begin
    if (rst_i) ph_ff <= ssx_pkg::SSX_PH_IDLE;
    else ph_ff <= nxt_ph;
  end

  // instruction word, loaded only when a cycle starts
  always_ff @(posedge clk_i) begin
    if (rst_i) instr_ff <= ssx_pkg::SSX_INSTR_RST;
    else if (start) instr_ff <= wb_dat_i[13:0];
  end

  // q1 decode drives the address, q2 reads the operand
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_addr_ff <= 7'h00;
      opa_ff <= 8'h00;
    end else begin
      if (ph_ff == ssx_pkg::SSX_PH_Q1) file_addr_ff <= instr_ff[6:0];
      if (ph_ff == ssx_pkg::SSX_PH_Q2) opa_ff <= is_subl ? instr_ff[7:0] : file_rdata_i;
    end
  end

  // working register, hardware commit wins over a bus write
  always_ff @(posedge clk_i) begin
    if (rst_i) w_ff <= ssx_pkg::SSX_W_RST;
    else if (to_w) w_ff <= alu_bus.res;
    else if (wr_w) w_ff <= wb_dat_i[7:0];
  end

  // arithmetic flags, untouched by swap
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_ff <= 1'b0;
      dc_ff <= 1'b0;
      z_ff <= 1'b0;
    end else if (commit && alu_bus.flags_upd) begin
      c_ff <= alu_bus.c;
      dc_ff <= alu_bus.dc;
      z_ff <= alu_bus.z;
    end else if (wr_st) begin
      c_ff <= wb_dat_i[ssx_pkg::SSX_ST_C];
      dc_ff <= wb_dat_i[ssx_pkg::SSX_ST_DC];
      z_ff <= wb_dat_i[ssx_pkg::SSX_ST_Z];
    end
  end

  // power-down status and sleep state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pd_ff <= ssx_pkg::SSX_PD_RST;
      to_ff <= ssx_pkg::SSX_TO_RST;
      sleep_ff <= 1'b0;
    end else if (go_sleep) begin
      pd_ff <= 1'b0;
      to_ff <= 1'b1;
      sleep_ff <= 1'b1;
    end else if (wake) begin
      sleep_ff <= 1'b0;
    end
  end

  // one-cycle strobes: file write and watchdog clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      file_we_ff <= 1'b0;
      file_wdata_ff <= 8'h00;
      wdt_clr_ff <= 1'b0;
    end else begin
      file_we_ff <= to_file;
      if (to_file) file_wdata_ff <= alu_bus.res;
      wdt_clr_ff <= go_sleep;
    end
  end

  // bus answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      if (req) dat_ff <= rd;
    end
  end

  // outputs straight from flip-flops
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign file_addr_o = file_addr_ff;
  assign file_we_o = file_we_ff;
  assign file_wdata_o = file_wdata_ff;
  assign sleep_o = sleep_ff;
  assign osc_stop_o = sleep_ff;
  assign wdt_clr_o = wdt_clr_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [7:0] swap_ref = {opa_ff[3:0], opa_ff[7:4]};
  wire [7:0] subl_ref = instr_ff[7:0] - w_ff;
  wire c_ref = (opa_ff >= w_ff);
  wire z_ref = (opa_ff == w_ff); // zero result only when operands match

  property p_phases;
    ph_ff == ssx_pkg::SSX_PH_Q1 |=> ph_ff == ssx_pkg::SSX_PH_Q2 ##1 ph_ff == ssx_pkg::SSX_PH_Q3
      ##1 ph_ff == ssx_pkg::SSX_PH_Q4 ##1 ph_ff == ssx_pkg::SSX_PH_IDLE;
  endproperty
  a_phases: assert property (p_phases) else $error("phase order broken");
  property p_sleep_q4;
    (ph_ff == ssx_pkg::SSX_PH_Q1) && is_sleep |-> !sleep_o [*4] ##1 sleep_o;
  endproperty
  a_sleep_q4: assert property (p_sleep_q4) else $error("sleep not in q4");
  property p_sleep_bits;
    go_sleep |=> !pd_ff && to_ff && wdt_clr_o ##1 !wdt_clr_o;
  endproperty
  a_sleep_bits: assert property (p_sleep_bits) else $error("power-down bits wrong");
  property p_osc;
    go_sleep |=> osc_stop_o;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator not stopped");
  property p_subl;
    in_q4 && is_subl |=> w_ff == $past(subl_ref) && !file_we_o;
  endproperty
  a_subl: assert property (p_subl) else $error("literal subtract wrong");
  property p_carry;
    in_q4 && (is_subl || is_subf) |=> c_ff == $past(c_ref);
  endproperty
  a_carry: assert property (p_carry) else $error("borrow flag wrong");
  property p_zero;
    in_q4 && (is_subl || is_subf) |=> z_ff == $past(z_ref);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_subf_file;
    in_q4 && is_subf && dest_f |=> file_we_o && $stable(w_ff);
  endproperty
  a_subf_file: assert property (p_subf_file) else $error("file destination wrong");
  property p_swap_w;
    in_q4 && is_swap && !dest_f |=> w_ff == $past(swap_ref);
  endproperty
  a_swap_w: assert property (p_swap_w) else $error("swap to w wrong");
  property p_swap_f;
    in_q4 && is_swap && dest_f |=> file_wdata_o == $past(swap_ref) && file_we_o;
  endproperty
  a_swap_f: assert property (p_swap_f) else $error("swap to file wrong");
  property p_swap_flags;
    in_q4 && is_swap && !wr_st |=> $stable(c_ff) && $stable(dc_ff) && $stable(z_ff);
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap changed flags");
  property p_decode;
    start && (wb_dat_i[13:9] == 5'h1E) |=> is_subl;
  endproperty
  a_decode: assert property (p_decode) else $error("literal subtract not decoded");

  c_subl: cover property (in_q4 && is_subl && !alu_bus.c);
  c_subf: cover property (in_q4 && is_subf && dest_f);
  c_swap: cover property (in_q4 && is_swap);
  c_sleep: cover property (go_sleep ##[1:20] wake);
endmodule

// File: tb/tb_top.sv
// self-checking bench for the subtract, nibble swap and power-down execution core
`timescale 1ns/100ps
module tb_top;
  // ****************************************************************
  // stimulus and observation signals
  // ****************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000, rd, dat_o;
  logic ack, fwe, sleep, osc_stop, wdt_clr;
  logic [6:0] faddr;
  logic [7:0] frdata = 8'h00, fwdata, we_data;
  int errors = 0, checks = 0, we_cnt = 0, clr_cnt = 0;
  // clock and design under test
  always #20 clk_i = ~clk_i;
  ssx_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .file_addr_o(faddr), .file_rdata_i(frdata), .file_we_o(fwe), .file_wdata_o(fwdata),
    .sleep_o(sleep), .osc_stop_o(osc_stop), .wdt_clr_o(wdt_clr));
  // pulse counters for file writes and watchdog clears
  always @(posedge clk_i) begin
    if (fwe === 1'b1) begin
      we_cnt++;
      we_data = fwdata;
    end
    if (wdt_clr === 1'b1) clr_cnt++;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one classic wishbone cycle, waits for ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk_i);
    end
    if (n >= 20) cmp("ack", 32'h1, 32'h0);
    rd = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(name, exp, rd);
  endtask
  // start an instruction, let its four quarter-cycles pass plus one edge
  // so the pulse counters have seen the q4 strobes before anyone reads them
  task automatic exec(input logic [13:0] op);
    we_cnt = 0;
    clr_cnt = 0;
    bus(1'b1, ssx_pkg::SSX_ADR_INSTR, {18'h0, op});
    repeat (5) @(posedge clk_i);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'h0);
    rdc("status", ssx_pkg::SSX_ADR_STATUS, 32'h18);
    rdc("unmapped", 8'h0C, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_sub_lit();
    bus(1'b1, ssx_pkg::SSX_ADR_WREG, 32'h3);
    exec(14'h3C02);
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'hFF);
    rdc("status", ssx_pkg::SSX_ADR_STATUS, 32'h18);
    bus(1'b1, ssx_pkg::SSX_ADR_WREG, 32'h2);
    exec(14'h3D02);
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'h0);
    rdc("status", ssx_pkg::SSX_ADR_STATUS, 32'h1F);
    $display("test literal subtract done");
  endtask
  task automatic t_sub_file();
    bus(1'b1, ssx_pkg::SSX_ADR_WREG, 32'h2);
    frdata <= 8'h01;
    exec(14'h02A5);
    cmp("file_addr", 32'h25, {25'h0, faddr});
    cmp("file_we", 32'h1, we_cnt);
    cmp("file_wdata", 32'hFF, {24'h0, we_data});
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'h2);
    rdc("status", ssx_pkg::SSX_ADR_STATUS, 32'h18);
    frdata <= 8'h03;
    exec(14'h0225);
    cmp("file_we", 32'h0, we_cnt);
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'h1);
    rdc("status", ssx_pkg::SSX_ADR_STATUS, 32'h1B);
    $display("test file subtract done");
  endtask
  task automatic t_swap();
    frdata <= 8'hA5;
    exec(14'h0E10);
    cmp("file_we", 32'h0, we_cnt);
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'h5A);
    rdc("status", ssx_pkg::SSX_ADR_STATUS, 32'h1B);
    frdata <= 8'h3C;
    exec(14'h0E90);
    cmp("file_we", 32'h1, we_cnt);
    cmp("file_wdata", 32'hC3, {24'h0, we_data});
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'h5A);
    $display("test nibble swap done");
  endtask
  task automatic t_sleep();
    exec(ssx_pkg::SSX_OPC_SLEEP);
    cmp("sleep", 32'h1, {31'h0, sleep});
    cmp("osc_stop", 32'h1, {31'h0, osc_stop});
    cmp("wdt_clr", 32'h1, clr_cnt);
    rdc("status", ssx_pkg::SSX_ADR_STATUS, 32'h33);
    bus(1'b1, ssx_pkg::SSX_ADR_WREG, 32'h7);
    exec(14'h3C09);
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'h7);
    bus(1'b1, ssx_pkg::SSX_ADR_STATUS, 32'h83);
    cmp("osc_stop", 32'h0, {31'h0, osc_stop});
    exec(14'h3C09);
    rdc("wreg", ssx_pkg::SSX_ADR_WREG, 32'h2);
    rdc("status", ssx_pkg::SSX_ADR_STATUS, 32'h13);
    $display("test power-down done");
  endtask
  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_sub_lit();
    t_sub_file();
    t_swap();
    t_sleep();
    print_verdict();
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
endmodule
